// file: design/relay_cmd_pkg.sv
package relay_cmd_pkg;

  // word-serial command codes carried in the upper byte of a command word
  localparam logic [7:0] WCMD_BEGIN_NORMAL = 8'hFC;
  localparam logic [7:0] WCMD_BYTE_AVAIL   = 8'hBC;
  localparam logic [7:0] WCMD_BYTE_REQ     = 8'hDE;
  localparam logic [7:0] WCMD_CLEAR        = 8'hFF;
  localparam logic [7:0] WCMD_CLEAR_LOCK   = 8'hFD;
  localparam logic [7:0] WCMD_SET_LOCK     = 8'hEF;
  localparam logic [7:0] WCMD_READ_PROTO   = 8'hE7;
  localparam logic [7:0] WCMD_READ_STB     = 8'hCF;
  localparam logic [7:0] WCMD_TRIGGER      = 8'hED;

  // parsed high-level operations, issued by the text parser
  localparam logic [3:0] OP_NONE     = 4'h0;
  localparam logic [3:0] OP_CLOSE    = 4'h1;
  localparam logic [3:0] OP_OPEN     = 4'h2;
  localparam logic [3:0] OP_QCLOSE   = 4'h3;
  localparam logic [3:0] OP_QOPEN    = 4'h4;
  localparam logic [3:0] OP_SCANADD  = 4'h5;
  localparam logic [3:0] OP_RENAME   = 4'h6;
  localparam logic [3:0] OP_ERRQ     = 4'h7;
  localparam logic [3:0] OP_ESRQ     = 4'h8;
  localparam logic [3:0] OP_CLS      = 4'h9;
  localparam logic [3:0] OP_SCANCLR  = 4'hA;
  localparam logic [3:0] OP_SRCBUS   = 4'hB;
  localparam logic [3:0] OP_INIT     = 4'hC;
  localparam logic [3:0] OP_SCANMODE = 4'hD;

  // status byte and event status bit positions
  localparam int STB_ERRQ_BIT = 2;
  localparam int STB_MAV_BIT  = 4;
  localparam int ESR_EXE_BIT  = 4;
  localparam int ESR_CMD_BIT  = 5;

  // response register bit positions
  localparam int RESP_LOCK_BIT = 7;
  localparam int RESP_DOR_BIT  = 11;

  // error codes placed in the error queue
  localparam logic [7:0] ERR_SYNTAX = 8'h9E;
  localparam logic [7:0] ERR_RANGE  = 8'hDE;

  // protocol word, arbitrary value
  localparam logic [15:0] PROTOCOL_WORD = 16'h0A5F;

  // apb register map
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_RESP   = 8'h04;
  localparam logic [7:0] ADDR_DATA   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  localparam logic [15:0] RESP_RESET = 16'h0000;

endpackage

// file: design/relay_cmd_if.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/100ps
// Behaviour
// - channel list may span several modules
// - renamed module name addresses its channels; here the name is only stored, never read, and ops address by opMod
// - state queries answer in list order
// - scan closes next entry per trigger
// - one-per-section module keeps last channel
// - joined scan group keeps only last
// - section list fields, colon means range; here lo..hi only sets a whole-module scan flag
// - replies queued, stb bit4 while nonempty
// - response data-out-ready while output nonempty
// - errors queued, stb bit2 while nonempty
// - syntax error sets esr bit5
// - range error sets esr bit4
// - error query moves oldest error out
// - begin normal starts, idempotent
// - each byte-available delivers one byte
// - byte request returns next output byte
// - clear drops pending, keeps operations
// - lock set and cleared by command
// - read stb and protocol answered
// - bus trigger steps scan when selected
// - esr query returns then clears
// - clear-status empties events and queues
module relay_cmd_if
  import relay_cmd_pkg::*;
#(
  parameter int MODS  = 8,
  parameter int CHANS = 64,
  parameter int QDEP  = 16,
  parameter int SDEP  = 16
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      srst,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // parsed operations from the text parser
  input  wire logic                      opValid,
  input  wire logic [3:0]                opCode,
  input  wire logic [7:0]                opName,
  input  wire logic [$clog2(MODS)-1:0]   opMod,
  input  wire logic [$clog2(CHANS)-1:0]  opChan,
  input  wire logic [$clog2(CHANS)-1:0]  opSecLo,
  input  wire logic [$clog2(CHANS)-1:0]  opSecHi,
  input  wire logic                      opOneSec,
  input  wire logic                      opSyntaxErr,
  input  wire logic                      opRangeErr,
  // command text byte stream to the parser
  output logic                           cmdByteValid,
  output logic      [7:0]                cmdByte,
  output logic                           cmdFlush,
  // relay state and normal-operation flag
  output logic      [MODS*CHANS-1:0]     relayClosed,
  output logic                           normalOp
);

  localparam int MW = $clog2(MODS);
  localparam int CW = $clog2(CHANS);
  localparam int QW = $clog2(QDEP);
  localparam int SW = $clog2(SDEP);
  localparam int SECCH = 8; // channels per section on one-per-section modules

  typedef struct packed {
    logic [QDEP-1:0][7:0]     outQ;
    logic [QW:0]              outCnt;
    logic [QDEP-1:0][7:0]     errQ;
    logic [QW:0]              errCnt;
    logic [MODS-1:0][7:0]     names;
    logic [MODS*CHANS-1:0]    relays;
    logic [MODS-1:0]          oneSec;
    logic [MODS-1:0]          scanMode;
    logic [SDEP-1:0][MW+CW-1:0] scanList;
    logic [SW:0]              scanLen;
    logic [SW-1:0]            scanPos;
    logic                     srcBus;
    logic                     armed;
    logic [7:0]               esr;
    logic                     lockBit;
    logic                     normal;
    logic [31:0]              rdata;
    logic                     ready;
    logic                     byteValid;
    logic [7:0]               byteVal;
    logic                     flush;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  function automatic logic [7:0] stbOf(state_type s);
    stbOf = 8'h00;
    stbOf[STB_MAV_BIT]  = (s.outCnt != '0);
    stbOf[STB_ERRQ_BIT] = (s.errCnt != '0);
  endfunction

  function automatic int idxOf(logic [MW-1:0] m, logic [CW-1:0] c);
    idxOf = int'(m) * CHANS + int'(c);
  endfunction

  logic apbAcc;
  assign apbAcc = psel && penable && !st_r.ready;

  always_comb begin
    logic [7:0] w;
    logic [7:0] cmdHi;
    int b;
    w = 8'h00;
    cmdHi = 8'h00;
    b = 0;
    st_nxt = st_r;
    st_nxt.ready = 1'b0;
    st_nxt.byteValid = 1'b0;
    st_nxt.flush = 1'b0;
    // parsed operations
    if (opValid) begin
      if (opSyntaxErr || opRangeErr) begin
        if (opSyntaxErr) st_nxt.esr[ESR_CMD_BIT] = 1'b1;
        if (opRangeErr)  st_nxt.esr[ESR_EXE_BIT] = 1'b1;
        if (st_nxt.errCnt < QDEP[QW:0]) begin
          st_nxt.errQ[st_nxt.errCnt[QW-1:0]] = opSyntaxErr ? ERR_SYNTAX : ERR_RANGE;
          st_nxt.errCnt = st_nxt.errCnt + 1'b1;
        end
      end else begin
        case (opCode)
          OP_CLOSE: begin
            // each op names its own module; later closes win in scan-mode or one-per-section modules
            if (st_r.scanMode[opMod]) begin
              for (int c = 0; c < CHANS; c++)
                st_nxt.relays[idxOf(opMod, CW'(c))] = 1'b0;
            end else if (st_r.oneSec[opMod]) begin
              for (int c = 0; c < CHANS; c++)
                if (c / SECCH == int'(opChan) / SECCH)
                  st_nxt.relays[idxOf(opMod, CW'(c))] = 1'b0;
            end
            st_nxt.relays[idxOf(opMod, opChan)] = 1'b1;
          end
          OP_OPEN: st_nxt.relays[idxOf(opMod, opChan)] = 1'b0;
          OP_QCLOSE, OP_QOPEN: begin
            // replies queued in arrival order of the list entries
            if (st_nxt.outCnt < QDEP[QW:0]) begin
              w = st_r.relays[idxOf(opMod, opChan)] ^ (opCode == OP_QOPEN) ? 8'h31 : 8'h30;
              st_nxt.outQ[st_nxt.outCnt[QW-1:0]] = w;
              st_nxt.outCnt = st_nxt.outCnt + 1'b1;
            end
          end
          OP_SCANADD: begin
            if (st_r.scanLen < SDEP[SW:0]) begin
              st_nxt.scanList[st_r.scanLen[SW-1:0]] = {opMod, opChan};
              st_nxt.scanLen = st_r.scanLen + 1'b1;
            end
          end
          OP_SCANCLR: begin
            st_nxt.scanLen = '0;
            st_nxt.scanPos = '0;
            st_nxt.armed = 1'b0;
          end
          OP_RENAME: st_nxt.names[opMod] = opName;
          OP_SCANMODE: begin
            // section range lo..hi resolved to whole-module mode flag
            st_nxt.scanMode[opMod] = (opSecHi >= opSecLo);
            st_nxt.oneSec[opMod] = opOneSec;
          end
          OP_SRCBUS: st_nxt.srcBus = opName[0];
          OP_INIT: st_nxt.armed = (st_r.scanLen != '0);
          OP_ERRQ: begin
            if (st_r.errCnt != '0 && st_nxt.outCnt < QDEP[QW:0]) begin
              st_nxt.outQ[st_nxt.outCnt[QW-1:0]] = st_r.errQ[0];
              st_nxt.outCnt = st_nxt.outCnt + 1'b1;
              for (int i = 0; i < QDEP - 1; i++) st_nxt.errQ[i] = st_r.errQ[i+1];
              st_nxt.errCnt = st_r.errCnt - 1'b1;
            end
          end
          OP_ESRQ: begin
            if (st_nxt.outCnt < QDEP[QW:0]) begin
              st_nxt.outQ[st_nxt.outCnt[QW-1:0]] = st_r.esr;
              st_nxt.outCnt = st_nxt.outCnt + 1'b1;
            end
            st_nxt.esr = 8'h00;
          end
          OP_CLS: begin
            st_nxt.esr = 8'h00;
            st_nxt.errCnt = '0;
            st_nxt.outCnt = '0;
          end
          default: ;
        endcase
      end
    end
    // apb access, one wait state so pready comes from a flop
    if (apbAcc) begin
      st_nxt.ready = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      if (pwrite && paddr == ADDR_CMD) begin
        cmdHi = pwdata[15:8];
        if (cmdHi == WCMD_BEGIN_NORMAL) begin
          st_nxt.normal = 1'b1;
        end else if (cmdHi == WCMD_BYTE_AVAIL) begin
          st_nxt.byteValid = 1'b1;
          st_nxt.byteVal = pwdata[7:0];
        end else if (cmdHi == WCMD_BYTE_REQ) begin
          // pop the head; data read later at ADDR_DATA
          if (st_nxt.outCnt != '0) begin
            st_nxt.rdata = {24'h00_0000, st_nxt.outQ[0]};
            for (int i = 0; i < QDEP - 1; i++) st_nxt.outQ[i] = st_nxt.outQ[i+1];
            st_nxt.outCnt = st_nxt.outCnt - 1'b1;
          end
        end else if (cmdHi == WCMD_CLEAR) begin
          st_nxt.flush = 1'b1;
          st_nxt.outCnt = '0;
        end else if (cmdHi == WCMD_CLEAR_LOCK) begin
          st_nxt.lockBit = 1'b0;
        end else if (cmdHi == WCMD_SET_LOCK) begin
          st_nxt.lockBit = 1'b1;
        end else if (cmdHi == WCMD_READ_STB) begin
          st_nxt.rdata = {24'h00_0000, stbOf(st_nxt)};
        end else if (cmdHi == WCMD_READ_PROTO) begin
          st_nxt.rdata = {16'h0000, PROTOCOL_WORD};
        end else if (cmdHi == WCMD_TRIGGER) begin
          if (st_r.srcBus && st_r.armed && st_r.scanLen != '0) begin
            b = int'(st_r.scanPos);
            for (int c = 0; c < CHANS; c++)
              st_nxt.relays[idxOf(st_r.scanList[b][MW+CW-1:CW], CW'(c))] = 1'b0;
            st_nxt.relays[idxOf(st_r.scanList[b][MW+CW-1:CW],
                                st_r.scanList[b][CW-1:0])] = 1'b1;
            st_nxt.scanPos = (SW+1)'(b + 1) == st_r.scanLen ? '0 : SW'(b + 1);
          end
        end
      end else if (!pwrite) begin
        if (paddr == ADDR_RESP) begin
          st_nxt.rdata[RESP_DOR_BIT]  = (st_r.outCnt != '0);
          st_nxt.rdata[RESP_LOCK_BIT] = st_r.lockBit;
        end else if (paddr == ADDR_DATA) begin
          st_nxt.rdata = st_r.rdata;
        end else if (paddr == ADDR_STATUS) begin
          st_nxt.rdata = {16'h0000, st_r.esr, stbOf(st_r)};
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata       = st_r.rdata;
  assign pready       = st_r.ready;
  assign pslverr      = 1'b0;
  assign cmdByteValid = st_r.byteValid;
  assign cmdByte      = st_r.byteVal;
  assign cmdFlush     = st_r.flush;
  assign relayClosed  = st_r.relays;
  assign normalOp     = st_r.normal;

  a_mav_tracks: assert property (@(posedge clk_sys) disable iff (srst)
    opValid && !opSyntaxErr && !opRangeErr && opCode == OP_QCLOSE
    |=> st_r.outCnt != '0) else $error("mav flag wrong");
  a_esr_clear: assert property (@(posedge clk_sys) disable iff (srst)
    opValid && !opSyntaxErr && !opRangeErr && opCode == OP_ESRQ |=> st_r.esr == 8'h00)
    else $error("esr not cleared");
  a_syntax_esr: assert property (@(posedge clk_sys) disable iff (srst)
    opValid && opSyntaxErr |=> st_r.esr[ESR_CMD_BIT]) else $error("cmd error bit");
  a_range_esr: assert property (@(posedge clk_sys) disable iff (srst)
    opValid && opRangeErr && !opSyntaxErr |=> st_r.esr[ESR_EXE_BIT])
    else $error("exec error bit");
  a_lock_set: assert property (@(posedge clk_sys) disable iff (srst)
    apbAcc && pwrite && paddr == ADDR_CMD && pwdata[15:8] == WCMD_SET_LOCK
    |=> st_r.lockBit) else $error("lock not set");
  a_begin_norm: assert property (@(posedge clk_sys) disable iff (srst)
    $past(st_r.normal) |-> st_r.normal) else $error("normal dropped");
  a_byte_pass: assert property (@(posedge clk_sys) disable iff (srst)
    apbAcc && pwrite && paddr == ADDR_CMD && pwdata[15:8] == WCMD_BYTE_AVAIL
    |=> cmdByteValid && cmdByte == $past(pwdata[7:0])) else $error("byte lost");
  a_apb_ready: assert property (@(posedge clk_sys) disable iff (srst)
    psel && penable && !pready |=> pready) else $error("pready late");
  c_trigger: cover property (@(posedge clk_sys) apbAcc && pwdata[15:8] == WCMD_TRIGGER);
  c_errq: cover property (@(posedge clk_sys) st_r.errCnt != '0 ##[1:20] st_r.errCnt == '0);
  c_query: cover property (@(posedge clk_sys) opValid && opCode == OP_QCLOSE);

endmodule // relay_cmd_if

// file: test/relay_commander.sv
`timescale 1ns/100ps
module relay_commander
  import relay_cmd_pkg::*;
(
  // clock
  input  wire logic        clk_sys,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // opens on its own edge so back-to-back calls never assign twice in a step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released data lines toggle so a stale value cannot pass
    pwdata  <= ~d;
  endtask

  // one word command, one byte of text at most
  task automatic cmd(input logic [7:0] code, input logic [7:0] arg);
    logic [31:0] rd;
    xfer(1'b1, ADDR_CMD, {16'h0000, code, arg}, rd);
  endtask

  task automatic get_byte(output logic [7:0] b, output logic dor);
    logic [31:0] rd;
    int n;
    n = 0;
    do begin
      xfer(1'b0, ADDR_RESP, 32'h0000_0000, rd);
      n++;
    end while (rd[RESP_DOR_BIT] !== 1'b1 && n < 16);
    dor = rd[RESP_DOR_BIT];
    cmd(WCMD_BYTE_REQ, 8'h00);
    xfer(1'b0, ADDR_DATA, 32'h0000_0000, rd);
    b = rd[7:0];
  endtask
endmodule // relay_commander

// file: test/relay_switch_command_status_interface_bench.sv
`timescale 1ns/100ps
module relay_switch_command_status_interface_bench;
  import relay_cmd_pkg::*;
  localparam int MODS  = 4;
  localparam int CHANS = 16;
  logic                  clk_sys, srst, psel, penable, pwrite, pready;
  logic                  opValid, opOneSec, opSyntaxErr, opRangeErr;
  logic                  cmdByteValid, cmdFlush, normalOp, flushSeen;
  logic [7:0]            paddr, opName, cmdByte, lastByte;
  logic [31:0]           pwdata, prdata;
  logic [3:0]            opCode, opChan, opSecLo, opSecHi;
  logic [1:0]            opMod;
  logic [MODS*CHANS-1:0] relayClosed;
  int                    error_cnt, num_checks;

  relay_cmd_if #(.MODS(MODS), .CHANS(CHANS)) u_dut (.clk_sys, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(), .opValid, .opCode, .opName,
    .opMod, .opChan, .opSecLo, .opSecHi, .opOneSec, .opSyntaxErr, .opRangeErr,
    .cmdByteValid, .cmdByte, .cmdFlush, .relayClosed, .normalOp);
  relay_commander u_cmdr (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready);

  function automatic int idx(int m, int c);
    return m * CHANS + c;
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic op(input logic [3:0] c, input int m, input int ch, input logic [7:0] nm,
                    input logic [2:0] fl);
    @(posedge clk_sys);
    opValid  <= 1'b1;
    opCode   <= c;
    opMod    <= 2'(m);
    opChan   <= 4'(ch);
    opSecLo  <= 4'(ch);
    // high bound from the name field so a range can be empty (hi below lo)
    opSecHi  <= 4'(nm);
    opName   <= nm;
    {opOneSec, opSyntaxErr, opRangeErr} <= fl;
    @(posedge clk_sys);
    opValid  <= 1'b0;
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (cmdByteValid === 1'b1) lastByte <= cmdByte;
    if (cmdFlush === 1'b1) flushSeen <= 1'b1;
  end

  initial begin
    #200_000;
    error_cnt++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    logic [31:0] rd, st;
    logic [7:0]  b;
    logic        dor;
    int          c1, c2;
    {opValid, opOneSec, opSyntaxErr, opRangeErr, flushSeen} = '0;
    {opCode, opChan, opSecLo, opSecHi, opMod, opName, lastByte} = '0;
    error_cnt = 0;
    num_checks = 0;
    srst = 1'b1;
    void'($urandom(20));
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    // second begin must leave the running state alone
    u_cmdr.cmd(WCMD_BEGIN_NORMAL, 8'h00);
    u_cmdr.cmd(WCMD_BEGIN_NORMAL, 8'h00);
    settle();
    chk("normalOp", 1, normalOp);
    repeat (4) begin
      b = 8'($urandom);
      u_cmdr.cmd(WCMD_BYTE_AVAIL, b);
      settle();
      chk("cmdByte", b, lastByte);
    end
    $display("test start and bytes done");
    u_cmdr.cmd(WCMD_SET_LOCK, 8'h00);
    u_cmdr.xfer(1'b0, ADDR_RESP, 32'h0000_0000, rd);
    chk("lock set", 1, rd[RESP_LOCK_BIT]);
    u_cmdr.cmd(WCMD_CLEAR_LOCK, 8'h00);
    u_cmdr.xfer(1'b0, ADDR_RESP, 32'h0000_0000, rd);
    chk("lock clear", 0, rd[RESP_LOCK_BIT]);
    $display("test lock done");
    // adjacent channels share a section of 8
    c1 = $urandom_range(6, 0);
    c2 = c1 + 1;
    // module 1 one-per-section, empty section range keeps scan mode off
    op(OP_SCANMODE, 1, 1, 8'h00, 3'b100);
    op(OP_CLOSE, 1, c1, 8'h00, 3'b100);
    op(OP_CLOSE, 1, c2, 8'h00, 3'b100);
    op(OP_CLOSE, 3, c1, 8'h00, 3'b000);
    settle();
    chk("one per section first", 0, relayClosed[idx(1, c1)]);
    chk("one per section last", 1, relayClosed[idx(1, c2)]);
    chk("second module", 1, relayClosed[idx(3, c1)]);
    op(OP_QCLOSE, 3, c1, 8'h00, 3'b000);
    op(OP_QOPEN, 3, c1, 8'h00, 3'b000);
    settle();
    u_cmdr.xfer(1'b0, ADDR_STATUS, 32'h0000_0000, st);
    chk("mav set", 1, st[STB_MAV_BIT]);
    u_cmdr.get_byte(b, dor);
    chk("dor set", 1, dor);
    chk("close query", 8'h31, b);
    u_cmdr.get_byte(b, dor);
    chk("open query", 8'h30, b);
    u_cmdr.xfer(1'b0, ADDR_STATUS, 32'h0000_0000, st);
    u_cmdr.xfer(1'b0, ADDR_RESP, 32'h0000_0000, rd);
    chk("flags drop", 0, {st[STB_MAV_BIT], rd[RESP_DOR_BIT]});
    $display("test queries done");
    op(OP_CLOSE, 0, 0, 8'h00, 3'b010);
    op(OP_CLOSE, 0, 0, 8'h00, 3'b001);
    settle();
    u_cmdr.xfer(1'b0, ADDR_STATUS, 32'h0000_0000, st);
    chk("errq flag", 1, st[STB_ERRQ_BIT]);
    chk("cmd error", 1, st[8 + ESR_CMD_BIT]);
    chk("exe error", 1, st[8 + ESR_EXE_BIT]);
    op(OP_ERRQ, 0, 0, 8'h00, 3'b000);
    u_cmdr.get_byte(b, dor);
    chk("oldest error", ERR_SYNTAX, b);
    op(OP_ESRQ, 0, 0, 8'h00, 3'b000);
    settle();
    u_cmdr.xfer(1'b0, ADDR_STATUS, 32'h0000_0000, st);
    chk("esr cleared", 0, st[15:8]);
    op(OP_CLS, 0, 0, 8'h00, 3'b000);
    settle();
    u_cmdr.xfer(1'b0, ADDR_STATUS, 32'h0000_0000, st);
    chk("clear status", 0, {st[15:8], st[STB_MAV_BIT], st[STB_ERRQ_BIT]});
    $display("test errors done");
    op(OP_SCANCLR, 2, 0, 8'h00, 3'b000);
    op(OP_SCANADD, 2, c1, 8'h00, 3'b000);
    op(OP_SCANADD, 2, c2, 8'h00, 3'b000);
    op(OP_SRCBUS, 0, 0, 8'h00, 3'b000);
    op(OP_INIT, 0, 0, 8'h00, 3'b000);
    u_cmdr.cmd(WCMD_TRIGGER, 8'h00);
    settle();
    chk("trigger not bus", 0, relayClosed[idx(2, c1)]);
    op(OP_SRCBUS, 0, 0, 8'h01, 3'b000);
    op(OP_INIT, 0, 0, 8'h00, 3'b000);
    u_cmdr.cmd(WCMD_TRIGGER, 8'h00);
    settle();
    chk("scan first", 1, relayClosed[idx(2, c1)]);
    u_cmdr.cmd(WCMD_TRIGGER, 8'h00);
    settle();
    chk("scan second", 1, relayClosed[idx(2, c2)]);
    op(OP_SCANMODE, 0, 0, 8'h01, 3'b000);
    op(OP_CLOSE, 0, c1, 8'h00, 3'b000);
    op(OP_CLOSE, 0, c2 + 8, 8'h00, 3'b000);
    settle();
    chk("scan group", 32'(1) << (c2 + 8), relayClosed[CHANS-1:0]);
    $display("test scan done");
    u_cmdr.cmd(WCMD_CLEAR, 8'h00);
    settle();
    chk("flush", 1, flushSeen);
    chk("relay kept", 1, relayClosed[idx(3, c1)]);
    u_cmdr.cmd(WCMD_READ_STB, 8'h00);
    u_cmdr.xfer(1'b0, ADDR_DATA, 32'h0000_0000, rd);
    u_cmdr.xfer(1'b0, ADDR_STATUS, 32'h0000_0000, st);
    chk("read stb", 8'h00, rd[7:0]);
    chk("stb status", 8'h00, st[7:0]);
    u_cmdr.cmd(WCMD_READ_PROTO, 8'h00);
    u_cmdr.xfer(1'b0, ADDR_DATA, 32'h0000_0000, rd);
    chk("protocol", PROTOCOL_WORD, rd[15:0]);
    u_cmdr.xfer(1'b0, 8'h10, 32'h0000_0000, rd);
    chk("unmapped", 0, rd);
    $display("test word commands done");
    final_report();
  end
endmodule // relay_switch_command_status_interface_bench
